//--- qos_classifier_queue_scheduler.v
/*
 * Per-port QoS classifier with four egress queues and a scheduler, plus an
 * AXI4-Lite register slave. Assumes one clock and frame descriptors offered
 * one per cycle at most by the ingress side.
 */
`timescale 1ns/10ps
`include "qos_map.vh"

module qos_classifier_queue_scheduler (
	input  wire                   aclk,
	input  wire                   aresetn,
	input  wire                   awvalid,
	output wire                   awready,
	input  wire [`QOS_AW-1:0]     awaddr,
	input  wire                   wvalid,
	output wire                   wready,
	input  wire [31:0]            wdata,
	input  wire [3:0]             wstrb,
	output wire                   bvalid,
	input  wire                   bready,
	output wire [1:0]             bresp,
	input  wire                   arvalid,
	output wire                   arready,
	input  wire [`QOS_AW-1:0]     araddr,
	output wire                   rvalid,
	input  wire                   rready,
	output wire [31:0]            rdata,
	output wire [1:0]             rresp,
	input  wire                   in_valid,
	output wire                   in_ready,
	input  wire [3:0]             in_port,
	input  wire                   in_tagged,
	input  wire [2:0]             in_user_prio,
	input  wire                   in_ipv4,
	input  wire [7:0]             in_service,
	input  wire [`QOS_REF_W-1:0]  in_ref,
	output wire                   out_valid,
	input  wire                   out_ready,
	output wire [`QOS_REF_W-1:0]  out_ref,
	output wire [1:0]             out_queue,
	output wire [2:0]             out_prio
);
	// ----------------------------------------
	// Configuration state
	// ----------------------------------------
	reg [1:0]  mode_ff;
	reg [1:0]  sched_ff;
	reg        dscp_en_ff;
	reg [15:0] weight_ff;
	reg [15:0] qmap_ff;
	reg [`QOS_NUM_PORTS-1:0] dscp_pen_ff;
	reg [3:0]  port_cfg_ff [0:`QOS_NUM_PORTS-1];
	reg [2:0]  dscp_tab_ff [0:`QOS_NUM_DSCP-1];

	// ----------------------------------------
	// Bus slave state
	// ----------------------------------------
	reg                aw_hold_ff;
	reg [`QOS_AW-1:0]  aw_addr_ff;
	reg                w_hold_ff;
	reg [31:0]         w_data_ff;
	reg [3:0]          w_strb_ff;
	reg                bvalid_ff;
	reg [1:0]          bresp_ff;
	reg                rvalid_ff;
	reg [31:0]         rdata_ff;
	reg [1:0]          rresp_ff;

	// ----------------------------------------
	// Queue and scheduler state
	// ----------------------------------------
	reg [`QOS_STAMP_W-1:0] seq_ff;
	reg [1:0]              cur_q_ff;
	reg [3:0]              wrr_cnt_ff;
	reg                    out_valid_ff;
	reg [`QOS_REF_W-1:0]   out_ref_ff;
	reg [1:0]              out_queue_ff;
	reg [2:0]              out_prio_ff;

	wire [`QOS_ENTRY_W-1:0] q_head [0:`QOS_NUM_Q-1];
	wire [`QOS_FIFO_AW:0]   q_count [0:`QOS_NUM_Q-1];
	wire [`QOS_NUM_Q-1:0]   q_empty;
	wire [`QOS_NUM_Q-1:0]   q_full;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (strb[b])
					merge[8*b +: 8] = data[8*b +: 8];
		end
	endfunction

	// ----------------------------------------
	// Classification
	// ----------------------------------------
	wire       port_ok  = (in_port >= 4'h1) && (in_port <= `QOS_NUM_PORTS);
	wire [3:0] port_idx = port_ok ? (in_port - 4'h1) : 4'h0;
	wire [5:0] dscp     = in_service[7:2];        // Low two bits are must-be-zero

	reg       cls_src;
	reg [2:0] cls_prio;
	reg [1:0] cls_q;

	always @* begin
		cls_src  = 1'b0;
		cls_prio = 3'h0;
		case (mode_ff)
			`QOS_MODE_TAG: begin
				cls_src  = in_tagged;
				cls_prio = in_user_prio;
			end
			`QOS_MODE_DSCP: begin
				cls_src  = in_ipv4 && dscp_en_ff && port_ok
				           && dscp_pen_ff[port_idx];
				cls_prio = dscp_tab_ff[dscp];
			end
			`QOS_MODE_PORT: begin
				cls_src  = port_ok && port_cfg_ff[port_idx][`QOS_PORT_EN_BIT];
				cls_prio = port_cfg_ff[port_idx][2:0];
			end
			default: begin
				cls_src  = 1'b0;
				cls_prio = 3'h0;
			end
		endcase
		if (!cls_src)
			cls_prio = 3'h0;
		// Unclassified frames bypass the map table
		cls_q = cls_src ? qmap_ff[{cls_prio, 1'b0} +: 2] : `QOS_Q_LOWEST;
	end

	// Back-pressure only from the queue this frame is headed for
	assign in_ready = !q_full[cls_q];
	wire   in_take  = in_valid && in_ready;

	// ----------------------------------------
	// Scheduler selection
	// ----------------------------------------
	reg                    sel_ok;
	reg [1:0]              sel_q;
	reg [`QOS_STAMP_W-1:0] age;
	reg [`QOS_STAMP_W-1:0] best_age;
	reg [1:0]              cand;
	reg [3:0]              wt;
	integer                i;

	always @* begin
		sel_ok   = 1'b0;
		sel_q    = 2'h0;
		age      = {`QOS_STAMP_W{1'b0}};
		best_age = {`QOS_STAMP_W{1'b0}};
		cand     = 2'h0;
		wt       = weight_ff[{cur_q_ff, 2'h0} +: 4];
		if (wt == 4'h0)
			wt = 4'h1;
		case (sched_ff)
			`QOS_SCHED_FCFS: begin
				// Stamps wrap, but at most sixteen frames wait, so age never aliases
				for (i = 0; i < `QOS_NUM_Q; i = i + 1) begin
					age = seq_ff - q_head[i][`QOS_STAMP_W-1:0];
					if (!q_empty[i] && (!sel_ok || age > best_age)) begin
						sel_ok   = 1'b1;
						sel_q    = i[1:0];
						best_age = age;
					end
				end
			end
			`QOS_SCHED_STRICT: begin
				for (i = 0; i < `QOS_NUM_Q; i = i + 1)
					if (!q_empty[i]) begin
						sel_ok = 1'b1;
						sel_q  = i[1:0];
					end
			end
			`QOS_SCHED_WRR: begin
				if (!q_empty[cur_q_ff] && wrr_cnt_ff < wt) begin
					sel_ok = 1'b1;
					sel_q  = cur_q_ff;
				end else begin
					// Step down one queue at a time, wrapping from lowest to highest
					for (i = 1; i <= `QOS_NUM_Q; i = i + 1) begin
						cand = cur_q_ff - i[1:0];
						if (!sel_ok && !q_empty[cand]) begin
							sel_ok = 1'b1;
							sel_q  = cand;
						end
					end
				end
			end
			default: begin
				sel_ok = 1'b0;
				sel_q  = 2'h0;
			end
		endcase
	end

	wire load_out = sel_ok && (!out_valid_ff || out_ready);

	// ----------------------------------------
	// Egress queues
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < `QOS_NUM_Q; g = g + 1) begin : gen_q
			qos_fifo u_fifo (
				.aclk    (aclk),
				.aresetn (aresetn),
				.push    (in_take && (cls_q == g)),
				.din     ({in_ref, cls_prio, seq_ff}),
				.pop     (load_out && (sel_q == g)),
				.dout    (q_head[g]),
				.empty   (q_empty[g]),
				.full    (q_full[g]),
				.count   (q_count[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Scheduler and output stage
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			seq_ff       <= {`QOS_STAMP_W{1'b0}};
			cur_q_ff     <= `QOS_Q_HIGHEST;
			wrr_cnt_ff   <= 4'h0;
			out_valid_ff <= 1'b0;
			out_ref_ff   <= {`QOS_REF_W{1'b0}};
			out_queue_ff <= 2'h0;
			out_prio_ff  <= 3'h0;
		end else begin
			if (in_take)
				seq_ff <= seq_ff + 1'b1;
			if (load_out) begin
				out_valid_ff <= 1'b1;
				out_ref_ff   <= q_head[sel_q][`QOS_ENTRY_W-1 -: `QOS_REF_W];
				out_prio_ff  <= q_head[sel_q][`QOS_STAMP_W +: 3];
				out_queue_ff <= sel_q;
				if (sel_q == cur_q_ff) begin
					wrr_cnt_ff <= wrr_cnt_ff + 4'h1;
				end else begin
					cur_q_ff   <= sel_q;
					wrr_cnt_ff <= 4'h1;
				end
			end else if (out_ready) begin
				out_valid_ff <= 1'b0;
			end
		end
	end

	assign out_valid = out_valid_ff;
	assign out_ref   = out_ref_ff;
	assign out_queue = out_queue_ff;
	assign out_prio  = out_prio_ff;

	// ----------------------------------------
	// Register write path
	// ----------------------------------------
	assign awready = !aw_hold_ff;
	assign wready  = !w_hold_ff;
	assign bvalid  = bvalid_ff;
	assign bresp   = bresp_ff;

	wire do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
	wire wr_port  = (aw_addr_ff >= `QOS_OFF_PORT_LO) && (aw_addr_ff < `QOS_OFF_PORT_HI);
	wire wr_dscp  = (aw_addr_ff >= `QOS_OFF_DSCP_LO) && (aw_addr_ff < `QOS_OFF_DSCP_HI);
	wire [31:0] wr_old_ctrl = {27'h0, dscp_en_ff, sched_ff, mode_ff};
	wire [31:0] wr_ctrl  = merge(wr_old_ctrl, w_data_ff, w_strb_ff);
	wire [31:0] wr_wt    = merge({16'h0, weight_ff}, w_data_ff, w_strb_ff);
	wire [31:0] wr_qmap  = merge({16'h0, qmap_ff}, w_data_ff, w_strb_ff);
	wire [31:0] wr_pen   = merge({22'h0, dscp_pen_ff}, w_data_ff, w_strb_ff);
	wire [3:0]  wr_pidx  = aw_addr_ff[5:2];
	wire [5:0]  wr_didx  = aw_addr_ff[7:2];
	wire        wr_known = (aw_addr_ff == `QOS_OFF_CTRL) || (aw_addr_ff == `QOS_OFF_WEIGHT)
	                       || (aw_addr_ff == `QOS_OFF_QMAP) || (aw_addr_ff == `QOS_OFF_DSCP_PEN)
	                       || (aw_addr_ff == `QOS_OFF_STATUS) || wr_port || wr_dscp;
	integer k;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff  <= 1'b0;
			aw_addr_ff  <= {`QOS_AW{1'b0}};
			w_hold_ff   <= 1'b0;
			w_data_ff   <= 32'h0;
			w_strb_ff   <= 4'h0;
			bvalid_ff   <= 1'b0;
			bresp_ff    <= `QOS_RESP_OKAY;
			mode_ff     <= `QOS_MODE_TAG;
			sched_ff    <= `QOS_SCHED_FCFS;
			dscp_en_ff  <= 1'b0;
			weight_ff   <= `QOS_WEIGHT_RST;
			qmap_ff     <= `QOS_QMAP_RST;
			dscp_pen_ff <= {`QOS_NUM_PORTS{1'b0}};
			for (k = 0; k < `QOS_NUM_PORTS; k = k + 1)
				port_cfg_ff[k] <= 4'h0;
			for (k = 0; k < `QOS_NUM_DSCP; k = k + 1)
				dscp_tab_ff[k] <= 3'h0;
		end else begin
			if (awvalid && !aw_hold_ff) begin
				aw_hold_ff <= 1'b1;
				aw_addr_ff <= awaddr;
			end
			if (wvalid && !w_hold_ff) begin
				w_hold_ff <= 1'b1;
				w_data_ff <= wdata;
				w_strb_ff <= wstrb;
			end
			if (bvalid_ff && bready)
				bvalid_ff <= 1'b0;
			if (do_write) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wr_known ? `QOS_RESP_OKAY : `QOS_RESP_SLVERR;
				if (aw_addr_ff == `QOS_OFF_CTRL) begin
					mode_ff    <= wr_ctrl[`QOS_CTRL_MODE];
					sched_ff   <= wr_ctrl[`QOS_CTRL_SCHED];
					dscp_en_ff <= wr_ctrl[`QOS_CTRL_DSCP_EN];
				end
				if (aw_addr_ff == `QOS_OFF_WEIGHT)
					weight_ff <= wr_wt[15:0];
				if (aw_addr_ff == `QOS_OFF_QMAP)
					qmap_ff <= wr_qmap[15:0];
				if (aw_addr_ff == `QOS_OFF_DSCP_PEN)
					dscp_pen_ff <= wr_pen[`QOS_NUM_PORTS-1:0];
				if (wr_port && w_strb_ff[0])
					port_cfg_ff[wr_pidx] <= w_data_ff[3:0];
				// Table locked while codepoint classification is off
				if (wr_dscp && dscp_en_ff && w_strb_ff[0])
					dscp_tab_ff[wr_didx] <= w_data_ff[2:0];
			end
		end
	end

	// ----------------------------------------
	// Register read path
	// ----------------------------------------
	assign arready = !rvalid_ff;
	assign rvalid  = rvalid_ff;
	assign rdata   = rdata_ff;
	assign rresp   = rresp_ff;

	wire       rd_port = (araddr >= `QOS_OFF_PORT_LO) && (araddr < `QOS_OFF_PORT_HI);
	wire       rd_dscp = (araddr >= `QOS_OFF_DSCP_LO) && (araddr < `QOS_OFF_DSCP_HI);
	wire [3:0] rd_pidx = araddr[5:2];
	reg [31:0] rd_val;
	reg        rd_hit;

	always @* begin
		rd_val = 32'h0;
		rd_hit = 1'b1;
		case (araddr)
			`QOS_OFF_CTRL:     rd_val = {27'h0, dscp_en_ff, sched_ff, mode_ff};
			`QOS_OFF_WEIGHT:   rd_val = {16'h0, weight_ff};
			`QOS_OFF_QMAP:     rd_val = {16'h0, qmap_ff};
			`QOS_OFF_DSCP_PEN: rd_val = {22'h0, dscp_pen_ff};
			`QOS_OFF_STATUS:   rd_val = {16'h0, 1'b0, q_count[3], 1'b0, q_count[2],
			                             1'b0, q_count[1], 1'b0, q_count[0]};
			default: begin
				if (rd_port)
					rd_val = {28'h0, port_cfg_ff[rd_pidx]};
				else if (rd_dscp)
					rd_val = {29'h0, dscp_tab_ff[araddr[7:2]]};
				else
					rd_hit = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0;
			rresp_ff  <= `QOS_RESP_OKAY;
		end else if (arvalid && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_val;
			rresp_ff  <= rd_hit ? `QOS_RESP_OKAY : `QOS_RESP_SLVERR;
		end else if (rvalid_ff && rready) begin
			rvalid_ff <= 1'b0;
		end
	end
endmodule // qos_classifier_queue_scheduler

//--- qos_map.vh
/*
 * Register map, field positions, codes and sizes of the QoS classifier and
 * queue scheduler. Assumes the includer is plain Verilog-2005 on one clock.
 */
// Notes on behaviour
// - At most one of tag, DSCP, port modes; mode code 3 classifies nothing
// - Tag mode uses the tag's user priority
// - Four egress queues, highest to lowest
// - Priority 0 to 7, seven most important
// - Table maps each priority to a queue
// - FCFS sends strictly in arrival order
// - Strict mode empties higher queues first
// - WRR: per-queue weight frames, then next lower
// - Weights 8,4,2,1 give that round pattern
// - Port mode: per-port priority or disabled
// - Port settings kept for ports 1..10
// - DSCP mode takes codepoint from IPv4 frames
// - All 64 codepoints index the table
// - Table holds 64 entries of 0..7
// - Service octet split; must-be-zero ignored
// - Global DSCP enable gates table writes
// - Per-port DSCP enable for IPv4 frames
`ifndef QOS_MAP_VH
`define QOS_MAP_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define QOS_AW            12
`define QOS_OFF_CTRL      12'h000
`define QOS_OFF_WEIGHT    12'h004
`define QOS_OFF_QMAP      12'h008
`define QOS_OFF_DSCP_PEN  12'h00C
`define QOS_OFF_STATUS    12'h010
`define QOS_OFF_PORT_LO   12'h040
`define QOS_OFF_PORT_HI   12'h068
`define QOS_OFF_DSCP_LO   12'h100
`define QOS_OFF_DSCP_HI   12'h200

// ----------------------------------------
// Fields, codes and reset values
// ----------------------------------------
`define QOS_CTRL_MODE     1:0
`define QOS_CTRL_SCHED    3:2
`define QOS_CTRL_DSCP_EN  4
`define QOS_MODE_TAG      2'h0
`define QOS_MODE_DSCP     2'h1
`define QOS_MODE_PORT     2'h2
`define QOS_SCHED_FCFS    2'h0
`define QOS_SCHED_STRICT  2'h1
`define QOS_SCHED_WRR     2'h2
`define QOS_WEIGHT_RST    16'h8421
`define QOS_QMAP_RST      16'hFA50
`define QOS_PORT_EN_BIT   3
`define QOS_RESP_OKAY     2'h0
`define QOS_RESP_SLVERR   2'h2

// ----------------------------------------
// Sizes
// ----------------------------------------
`define QOS_NUM_PORTS     10
`define QOS_NUM_DSCP      64
`define QOS_NUM_Q         4
`define QOS_Q_LOWEST      2'h0
`define QOS_Q_HIGHEST     2'h3
`define QOS_FIFO_DEPTH    4
`define QOS_FIFO_AW       2
`define QOS_REF_W         8
`define QOS_STAMP_W       5
`define QOS_ENTRY_W       16

`endif

//--- qos_fifo.v
/*
 * One egress queue: a small first-in first-out store in flip-flops.
 * Assumes the owner never pushes when full nor pops when empty.
 */
`timescale 1ns/10ps
`include "qos_map.vh"

module qos_fifo #(
	parameter WIDTH = `QOS_ENTRY_W,
	parameter DEPTH = `QOS_FIFO_DEPTH,
	parameter AW    = `QOS_FIFO_AW
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire             push,
	input  wire [WIDTH-1:0] din,
	input  wire             pop,
	output wire [WIDTH-1:0] dout,
	output wire             empty,
	output wire             full,
	output wire [AW:0]      count
);
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0]    wr_ff;
	reg [AW-1:0]    rd_ff;
	reg [AW:0]      cnt_ff;

	assign dout  = mem_ff[rd_ff];
	assign empty = (cnt_ff == {(AW+1){1'b0}});
	assign full  = (cnt_ff == DEPTH[AW:0]);
	assign count = cnt_ff;

	always @(posedge aclk) begin
		if (!aresetn) begin
			wr_ff  <= {AW{1'b0}};
			rd_ff  <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem_ff[wr_ff] <= din;
				wr_ff         <= wr_ff + 1'b1;
			end
			if (pop)
				rd_ff <= rd_ff + 1'b1;
			if (push && !pop)
				cnt_ff <= cnt_ff + 1'b1;
			else if (pop && !push)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule // qos_fifo

//--- qos_classifier_queue_scheduler_properties.sv
/*
 * Concurrent checks on the register bus and egress port of the QoS block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/10ps
`include "qos_map.vh"

module qos_port_checker (
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic                  awvalid,
	input wire logic                  awready,
	input wire logic [`QOS_AW-1:0]    awaddr,
	input wire logic                  wvalid,
	input wire logic                  wready,
	input wire logic                  bvalid,
	input wire logic                  bready,
	input wire logic [1:0]            bresp,
	input wire logic                  arvalid,
	input wire logic                  arready,
	input wire logic [`QOS_AW-1:0]    araddr,
	input wire logic                  rvalid,
	input wire logic                  rready,
	input wire logic [31:0]           rdata,
	input wire logic [1:0]            rresp,
	input wire logic                  out_valid,
	input wire logic                  out_ready,
	input wire logic [`QOS_REF_W-1:0] out_ref,
	input wire logic [1:0]            out_queue,
	input wire logic [2:0]            out_prio
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_wr_pair;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_take;
		arvalid && arready;
	endsequence
	// Nothing decodes from 12'h400 upwards
	sequence s_wr_unmapped;
		s_wr_pair ##0 (awaddr[11:10] != 2'h0);
	endsequence
	sequence s_rd_unmapped;
		s_rd_take ##0 (araddr[11:10] != 2'h0);
	endsequence

	a_write_answer: assert property (s_wr_pair |-> ##2 bvalid)
		else $error("no write response");
	a_write_unmapped: assert property (s_wr_unmapped |-> ##2 bresp == `QOS_RESP_SLVERR)
		else $error("unmapped write not refused");
	a_bresp_clear: assert property (bvalid && bready |=> !bvalid)
		else $error("write response not released");
	a_read_answer: assert property (s_rd_take |=> rvalid)
		else $error("no read data");
	a_read_unmapped: assert property (s_rd_unmapped |=>
		rresp == `QOS_RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read not refused");
	a_read_refuse: assert property (rvalid |-> !arready)
		else $error("read address taken while data pending");
	a_rdata_clear: assert property (rvalid && rready |=> !rvalid)
		else $error("read data not released");
	a_egress_hold: assert property (
		out_valid && !out_ready |=> out_valid && $stable({out_ref, out_queue, out_prio}))
		else $error("egress descriptor changed while stalled");
endmodule // qos_port_checker

bind qos_classifier_queue_scheduler qos_port_checker i_port_checker (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
	.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
	.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
	.araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
	.rresp(rresp), .out_valid(out_valid), .out_ready(out_ready),
	.out_ref(out_ref), .out_queue(out_queue), .out_prio(out_prio)
);

//--- egress_port_model.sv
/*
 * Egress port model: accepts descriptors at full rate or every other cycle.
 * Assumes the bench reads the registered copy of each frame it took.
 */
`timescale 1ns/10ps

module egress_port_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       slow,
	input  wire logic       out_valid,
	output logic            out_ready,
	input  wire logic [7:0] out_ref,
	input  wire logic [1:0] out_queue,
	input  wire logic [2:0] out_prio,
	output logic            seen_ff,
	output logic [7:0]      seen_ref_ff,
	output logic [1:0]      seen_queue_ff,
	output logic [2:0]      seen_prio_ff
);
	logic tick_ff;

	// Slow mode stalls every other cycle so held descriptors get exercised
	assign out_ready = !slow || tick_ff;

	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_ff <= 1'b0;
			seen_ff <= 1'b0;
		end else begin
			tick_ff <= !tick_ff;
			seen_ff <= out_valid && out_ready;
			seen_ref_ff <= out_ref;
			seen_queue_ff <= out_queue;
			seen_prio_ff <= out_prio;
		end
	end
endmodule // egress_port_model

//--- qos_classifier_queue_scheduler_test.sv
/*
 * Self-checking bench for the QoS classifier and queue scheduler.
 * Assumes the design, its header, the checker and the egress model.
 */
`timescale 1ns/10ps
`include "qos_map.vh"

module qos_classifier_queue_scheduler_test;
	typedef struct packed {
		logic [1:0] m;
		logic [3:0] p;
		logic       t;
		logic [2:0] u;
		logic       ip;
		logic [7:0] s;
		logic [1:0] q;
		logic [2:0] pr;
	} row_t;
	logic        aclk = 0, aresetn = 0, slow = 0, seen;
	logic        awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
	logic        awready, wready, bvalid, arready, rvalid, in_ready, out_valid, out_ready;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0]  wstrb = 4'hF, in_port = '0;
	logic [1:0]  bresp, rresp, out_queue, seen_queue, r;
	logic        in_valid = 0, in_tagged = 0, in_ipv4 = 0;
	logic [2:0]  in_user_prio = '0, out_prio, seen_prio;
	logic [7:0]  in_service = '0, in_ref = '0, out_ref, seen_ref;
	int          n_mismatch = 0, comparisons = 0, i, j, k;
	row_t        rows[$];
	logic [2:0]  ups[4] = '{3'h0, 3'h7, 3'h2, 3'h5};
	int          strict_idx[4] = '{1, 3, 2, 0};
	logic [7:0]  wrr_ref[7] = '{8'h60, 8'h61, 8'h64, 8'h66, 8'h62, 8'h63, 8'h65};
	logic [1:0]  wrr_q[7] = '{2'h3, 2'h3, 2'h2, 2'h0, 2'h3, 2'h3, 2'h2};
	logic [2:0]  wrr_p[7] = '{3'h7, 3'h7, 3'h5, 3'h0, 3'h7, 3'h7, 3'h5};

	qos_classifier_queue_scheduler i_dut (
		.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .in_valid(in_valid), .in_ready(in_ready),
		.in_port(in_port), .in_tagged(in_tagged), .in_user_prio(in_user_prio),
		.in_ipv4(in_ipv4), .in_service(in_service), .in_ref(in_ref),
		.out_valid(out_valid), .out_ready(out_ready), .out_ref(out_ref),
		.out_queue(out_queue), .out_prio(out_prio)
	);
	egress_port_model i_sink (
		.aclk(aclk), .aresetn(aresetn), .slow(slow), .out_valid(out_valid),
		.out_ready(out_ready), .out_ref(out_ref), .out_queue(out_queue),
		.out_prio(out_prio), .seen_ff(seen), .seen_ref_ff(seen_ref),
		.seen_queue_ff(seen_queue), .seen_prio_ff(seen_prio)
	);

	always #25 aclk = ~aclk;

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("wrong value %s expected %0h seen %0h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task automatic hung(input string nm);
		$display("wrong value %s expected answer seen timeout", nm);
		n_mismatch++;
		close_out();
	endtask
	task automatic do_reset;
		aresetn <= 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
	endtask
	// Address and data go out together; bready and rready stay high throughout
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		for (int n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) begin
				rs = bresp;
				return;
			end
		end
		hung("write");
	endtask
	task automatic wok(input logic [11:0] a, input logic [31:0] d);
		logic [1:0] rs;
		wr(a, d, rs);
		chk("bresp", `QOS_RESP_OKAY, rs);
	endtask
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1;
		for (int n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) begin
				chk(nm, e, rdata);
				chk("rresp", er, rresp);
				return;
			end
		end
		hung("read");
	endtask
	task automatic push(input logic [3:0] p, input logic t, input logic [2:0] u,
		input logic ip, input logic [7:0] s, input logic [7:0] rf);
		in_port <= p;
		in_tagged <= t;
		in_user_prio <= u;
		in_ipv4 <= ip;
		in_service <= s;
		in_ref <= rf;
		in_valid <= 1;
		for (int n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (in_ready) begin
				in_valid <= 0;
				in_ref <= ~rf;
				@(posedge aclk);
				return;
			end
		end
		hung("ingress");
	endtask
	task automatic get(input logic [7:0] rf, input logic [1:0] q, input logic [2:0] p);
		for (int n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (seen) begin
				chk("out_ref", rf, seen_ref);
				chk("out_queue", q, seen_queue);
				chk("out_prio", p, seen_prio);
				return;
			end
		end
		hung("egress");
	endtask

	initial begin
		do_reset();
		wok(12'h1B8, 32'h5);
		rchk("dscp46", 12'h1B8, 32'h0, `QOS_RESP_OKAY);
		wok(`QOS_OFF_CTRL, 32'h10);
		wok(12'h1B8, 32'h5);
		wok(12'h1FC, 32'h7);
		rchk("dscp46", 12'h1B8, 32'h5, `QOS_RESP_OKAY);
		wok(`QOS_OFF_DSCP_PEN, 32'h1);
		wok(12'h044, 32'h7);
		wok(12'h048, 32'hE);
		wok(12'h064, 32'hF);
		for (i = 0; i < 8; i++)
			rows.push_back('{2'h0, 4'h1, 1'b1, 3'(i), 1'b0, 8'h00,
				2'(`QOS_QMAP_RST >> (2 * i)), 3'(i)});
		rows.push_back('{2'h0, 4'h1, 1'b0, 3'h5, 1'b1, 8'hB8, 2'h0, 3'h0});
		rows.push_back('{2'h1, 4'h1, 1'b0, 3'h0, 1'b1, 8'hB9, 2'h2, 3'h5});
		rows.push_back('{2'h1, 4'h1, 1'b1, 3'h0, 1'b1, 8'hFC, 2'h3, 3'h7});
		rows.push_back('{2'h1, 4'h1, 1'b1, 3'h7, 1'b0, 8'hFC, 2'h0, 3'h0});
		rows.push_back('{2'h1, 4'h4, 1'b0, 3'h0, 1'b1, 8'hB8, 2'h0, 3'h0});
		rows.push_back('{2'h2, 4'h3, 1'b0, 3'h0, 1'b0, 8'h00, 2'h3, 3'h6});
		rows.push_back('{2'h2, 4'hA, 1'b0, 3'h0, 1'b0, 8'h00, 2'h3, 3'h7});
		rows.push_back('{2'h2, 4'h2, 1'b1, 3'h7, 1'b0, 8'h00, 2'h0, 3'h0});
		rows.push_back('{2'h2, 4'hB, 1'b1, 3'h7, 1'b0, 8'h00, 2'h0, 3'h0});
		rows.push_back('{2'h3, 4'h1, 1'b1, 3'h7, 1'b1, 8'hFC, 2'h0, 3'h0});
		foreach (rows[n]) begin
			wok(`QOS_OFF_CTRL, {27'h0, 1'b1, `QOS_SCHED_FCFS, rows[n].m});
			push(rows[n].p, rows[n].t, rows[n].u, rows[n].ip, rows[n].s, 8'(n));
			get(8'(n), rows[n].q, rows[n].pr);
		end
		$display("classification rows done");
		// Queues fill while nothing is scheduled, then drain by arrival and by priority
		for (j = 0; j < 2; j++) begin
			wok(`QOS_OFF_CTRL, 32'hC);
			for (i = 0; i < 4; i++)
				push(4'h1, 1'b1, ups[i], 1'b0, 8'h00, 8'h40 + 8'(i));
			rchk("status", `QOS_OFF_STATUS, 32'h1111, `QOS_RESP_OKAY);
			slow <= j[0];
			wok(`QOS_OFF_CTRL, j ? 32'h4 : 32'h0);
			for (i = 0; i < 4; i++) begin
				k = j ? strict_idx[i] : i;
				get(8'h40 + 8'(k), 2'(`QOS_QMAP_RST >> (2 * ups[k])), ups[k]);
			end
			$display("order test %0d done", j);
		end
		do_reset();
		rchk("ctrl", `QOS_OFF_CTRL, 32'h0, `QOS_RESP_OKAY);
		rchk("weight", `QOS_OFF_WEIGHT, {16'h0, `QOS_WEIGHT_RST}, `QOS_RESP_OKAY);
		rchk("qmap", `QOS_OFF_QMAP, {16'h0, `QOS_QMAP_RST}, `QOS_RESP_OKAY);
		rchk("port10", 12'h064, 32'h0, `QOS_RESP_OKAY);
		rchk("dscp46", 12'h1B8, 32'h0, `QOS_RESP_OKAY);
		rchk("unmapped", 12'h400, 32'h0, `QOS_RESP_SLVERR);
		wr(12'h400, 32'h1, r);
		chk("bresp", `QOS_RESP_SLVERR, r);
		$display("reset and decode done");
		wok(`QOS_OFF_WEIGHT, 32'h2111);
		wok(`QOS_OFF_CTRL, 32'hC);
		for (i = 0; i < 4; i++)
			push(4'h1, 1'b1, 3'h7, 1'b0, 8'h00, 8'h60 + 8'(i));
		for (i = 0; i < 2; i++)
			push(4'h1, 1'b1, 3'h5, 1'b0, 8'h00, 8'h64 + 8'(i));
		push(4'h1, 1'b1, 3'h0, 1'b0, 8'h00, 8'h66);
		in_user_prio <= 3'h7;
		in_valid <= 1;
		repeat (3) begin
			@(posedge aclk);
			chk("in_ready", 32'h0, in_ready);
		end
		in_valid <= 0;
		wok(`QOS_OFF_CTRL, 32'h8);
		for (i = 0; i < 7; i++)
			get(wrr_ref[i], wrr_q[i], wrr_p[i]);
		$display("weighted round done");
		close_out();
	end
endmodule // qos_classifier_queue_scheduler_test
